// *** sci_params.svh ***
// Constants of the SDRAM command interface: widths, encodings, mode fields
`ifndef SCI_PARAMS_SVH
`define SCI_PARAMS_SVH

// Pin widths, bank count and burst length width
`define SCI_ROW_W      12
`define SCI_COL_W      8
`define SCI_BANK_W     2
`define SCI_BANKS      4
`define SCI_DQ_W       16
`define SCI_BYTES      2
`define SCI_LEN_W      9

// Operation codes as {row strobe, column strobe, write select}, all active low
`define SCI_OP_MRS     3'h0
`define SCI_OP_REF     3'h1
`define SCI_OP_PRE     3'h2
`define SCI_OP_ACT     3'h3
`define SCI_OP_WR      3'h4
`define SCI_OP_RD      3'h5
`define SCI_OP_BST     3'h6
`define SCI_OP_NOP     3'h7

// Address bit that selects precharge of all banks
`define SCI_PALL_BIT   10

// Mode register field layout
`define SCI_MR_BL_LSB  0
`define SCI_MR_BL_W    3
`define SCI_MR_BT_BIT  3
`define SCI_MR_CL_LSB  4
`define SCI_MR_CL_W    3
`define SCI_MR_WB_BIT  9

// Burst length codes and the lengths they give
`define SCI_BL_1       3'h0
`define SCI_BL_2       3'h1
`define SCI_BL_4       3'h2
`define SCI_BL_8       3'h3
`define SCI_BL_FULL    3'h7
`define SCI_LEN_1      9'h001
`define SCI_LEN_2      9'h002
`define SCI_LEN_4      9'h004
`define SCI_LEN_8      9'h008
`define SCI_LEN_FULL   9'h100

// CAS latency code for two cycles; any other code runs as three
`define SCI_CL_2       3'h2

`endif

// *** sci_pkg.sv ***
// Types shared by the SDRAM command interface modules
`include "sci_params.svh"

package sci_pkg;

  // Decoded command of one link clock edge
  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_MRS,
    CMD_REF,
    CMD_SELF_REF,
    CMD_PRE,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_BST
  } sci_cmd_e;

  // Low power state of the internal clock
  typedef enum logic [1:0] {
    LP_RUN,
    LP_POWER_DOWN,
    LP_SUSPEND,
    LP_SELF_REFRESH
  } sci_lp_e;

  // One stage of the read data pipeline
  typedef struct packed {
    logic                 valid;
    logic [`SCI_DQ_W-1:0] data;
  } sci_pipe_s;

  // Whole state of the link clock domain except the storage arrays
  typedef struct packed {
    logic                                   cke_q;
    logic [`SCI_BYTES-1:0]                  dqm_q;
    logic [`SCI_ROW_W-1:0]                  mode;
    logic                                   mode_valid;
    logic [`SCI_BANKS-1:0]                  bank_active;
    logic [`SCI_BANKS-1:0][`SCI_ROW_W-1:0]  open_row;
    logic                                   burst_on;
    logic                                   burst_wr;
    logic [`SCI_BANK_W-1:0]                 burst_bank;
    logic [`SCI_COL_W-1:0]                  burst_start;
    logic [`SCI_LEN_W-1:0]                  burst_cnt;
    logic [`SCI_LEN_W-1:0]                  burst_len;
    sci_pipe_s                              rd0;
    sci_pipe_s                              rd1;
    logic [`SCI_DQ_W-1:0]                   dq_out;
    logic [`SCI_BYTES-1:0]                  dq_oe;
    sci_lp_e                                lp;
    logic [2:0]                             lp_flags;
  } sci_link_s;

endpackage

// *** sci_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps

module sci_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sci_sync_s;

  sci_sync_s s;
  sci_sync_s next_s;

  if (W < 1) begin : g_chk
    $error("sci_sync needs W of at least one");
  end

  // First stage feeds only the second
  always_comb begin
    next_s.meta = i_d;
    next_s.q    = s.meta;
  end

  // Both stages clear to zero under reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_q = s.q;

endmodule

// *** sci_core.sv ***
// SDRAM device command interface: decoder, bank state, mode register, data path
`timescale 1ns/1ps
`include "sci_params.svh"

// Overview of operation
// - Row address uses all twelve address lines, column address the low eight.
// - Precharge frees all banks when the all-bit is set, else the selected bank.
// - Bank select picks the bank at activation and at each column access.
// - Chip select high ignores new commands; a running burst carries on.
// - All inputs are sampled on the rising link clock edge and decoded there.
// - Byte mask high during reads turns that output byte off two cycles later.
// - Byte mask high during writes blocks that byte in the same cycle.
// - Clock gate low stops internal clock: power down, suspend or self refresh.
// - Mode register is undefined after power up until programmed.
// - All four strobes low set the mode register from the address lines.
// - Row strobe high, column strobe low is a column access; write select picks.
// - Read or write commands are accepted on every clock cycle, any active bank.
// - Chip select, row strobe, write select low, column strobe high is precharge.
module sci_core
  import sci_pkg::*;
#(
  parameter int MEM_ROW_BITS = 1,
  parameter int MEM_COL_BITS = 4
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_link_clk,
  input  wire logic                   i_clk_gate,
  input  wire logic                   i_chip_sel_n,
  input  wire logic                   i_row_strobe_n,
  input  wire logic                   i_col_strobe_n,
  input  wire logic                   i_write_sel_n,
  input  wire logic [`SCI_BANK_W-1:0] i_bank_sel_lines,
  input  wire logic [`SCI_ROW_W-1:0]  i_mux_addr_lines,
  input  wire logic [`SCI_DQ_W-1:0]   i_io_data_lines,
  output logic      [`SCI_DQ_W-1:0]   o_io_data_lines,
  output logic      [`SCI_BYTES-1:0]  o_io_data_lines_oe,
  input  wire logic                   i_upper_byte_mask,
  input  wire logic                   i_lower_byte_mask,
  output logic                        o_mode_valid,
  output logic      [`SCI_BANKS-1:0]  o_bank_active,
  output logic                        o_power_down,
  output logic                        o_suspend,
  output logic                        o_self_refresh
);

  localparam int MEM_AW = `SCI_BANK_W + MEM_ROW_BITS + MEM_COL_BITS;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int LANE_W    = `SCI_DQ_W / `SCI_BYTES;

  if (MEM_ROW_BITS < 1 || MEM_ROW_BITS > `SCI_ROW_W ||
      MEM_COL_BITS < 1 || MEM_COL_BITS > `SCI_COL_W) begin : g_chk
    $error("sci_core storage bits exceed the address width");
  end

  sci_link_s                s;
  sci_link_s                next_s;
  logic                     link_rst_n;
  sci_cmd_e                 cmd;
  logic [`SCI_BYTES-1:0]    dqm_now;
  logic                     acc_on;
  logic                     acc_wr;
  logic [`SCI_BANK_W-1:0]   acc_bank;
  logic [`SCI_COL_W-1:0]    acc_col;
  logic [MEM_AW-1:0]        acc_idx;
  logic [`SCI_BYTES-1:0]    wr_en;
  logic [`SCI_DQ_W-1:0]     rd_data;
  logic [`SCI_LEN_W-1:0]    new_len;
  logic                     cl_two;
  sci_pipe_s                out_sel;

  // Decode the strobes of one edge into a command
  // Deselect wins over every strobe pattern
  function automatic sci_cmd_e sci_decode(input logic cs_n, input logic [2:0] op,
                                          input logic cke);
    sci_cmd_e c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_DESELECT;
    end else begin
      case (op)
        `SCI_OP_MRS: c = CMD_MRS;
        `SCI_OP_REF: c = cke ? CMD_REF : CMD_SELF_REF;
        `SCI_OP_PRE: c = CMD_PRE;
        `SCI_OP_ACT: c = CMD_ACT;
        `SCI_OP_WR:  c = CMD_WR;
        `SCI_OP_RD:  c = CMD_RD;
        `SCI_OP_BST: c = CMD_BST;
        `SCI_OP_NOP: c = CMD_NOP;
        default:     c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Burst length from the mode register code
  function automatic logic [`SCI_LEN_W-1:0] sci_len(input logic [`SCI_MR_BL_W-1:0] code);
    logic [`SCI_LEN_W-1:0] l;
    case (code)
      `SCI_BL_2:    l = `SCI_LEN_2;
      `SCI_BL_4:    l = `SCI_LEN_4;
      `SCI_BL_8:    l = `SCI_LEN_8;
      `SCI_BL_FULL: l = `SCI_LEN_FULL;
      default:      l = `SCI_LEN_1;
    endcase
    return l;
  endfunction

  // Column of the current beat: wrap inside the burst, or invert bits when interleaved
  function automatic logic [`SCI_COL_W-1:0] sci_col(input logic [`SCI_COL_W-1:0] start,
                                                    input logic [`SCI_LEN_W-1:0] cnt,
                                                    input logic [`SCI_LEN_W-1:0] len,
                                                    input logic                  inter);
    logic [`SCI_COL_W-1:0] mask;
    logic [`SCI_COL_W-1:0] c;
    mask = `SCI_COL_W'(len - `SCI_LEN_1);
    c    = `SCI_COL_W'(cnt);
    if (inter) begin
      return start ^ (c & mask);
    end
    return (start & ~mask) | (`SCI_COL_W'(start + c) & mask);
  endfunction

  // Link side reset: asserted at once, released on the link clock
  // Keeps a release near a link edge from splitting state
  sci_sync #(
    .W (1)
  ) u_link_rst (
    .i_clk   (i_link_clk),
    .i_rst_n (i_rst_n),
    .i_d     (1'b1),
    .o_q     (link_rst_n)
  );

  // Command and mask sampling; pins already belong to the link clock
  assign cmd     = sci_decode(i_chip_sel_n,
                              {i_row_strobe_n, i_col_strobe_n, i_write_sel_n},
                              i_clk_gate);
  assign dqm_now = {i_upper_byte_mask, i_lower_byte_mask};
  assign cl_two  = s.mode[`SCI_MR_CL_LSB +: `SCI_MR_CL_W] == `SCI_CL_2;
  // Single-beat writes shorten writes only
  assign new_len = (cmd == CMD_WR && s.mode[`SCI_MR_WB_BIT]) ? `SCI_LEN_1 :
                   sci_len(s.mode[`SCI_MR_BL_LSB +: `SCI_MR_BL_W]);
  assign out_sel = cl_two ? s.rd0 : s.rd1;

  // Storage index from bank, low bits of the open row and low column bits
  // Higher address bits alias to keep storage small
  assign acc_idx = {acc_bank, s.open_row[acc_bank][MEM_ROW_BITS-1:0],
                    acc_col[MEM_COL_BITS-1:0]};

  // One byte lane of storage per generate iteration
  // Lane writes are gated at the mask's own edge
  for (genvar gb = 0; gb < `SCI_BYTES; gb++) begin : g_lane
    logic [LANE_W-1:0] mem [MEM_DEPTH];

    assign wr_en[gb] = acc_on & acc_wr & ~dqm_now[gb];
    assign rd_data[gb*LANE_W +: LANE_W] = mem[acc_idx];

    always_ff @(posedge i_link_clk) begin
      if (wr_en[gb]) begin
        mem[acc_idx] <= i_io_data_lines[gb*LANE_W +: LANE_W];
      end
    end
  end

  // Next state of the link domain
  always_comb begin
    next_s       = s;
    acc_on       = 1'b0;
    acc_wr       = 1'b0;
    acc_bank     = s.burst_bank;
    acc_col      = s.burst_start;
    next_s.cke_q = i_clk_gate;
    next_s.dqm_q = dqm_now;
    if (s.lp == LP_SELF_REFRESH) begin
      // Only the clock gate is heard until it returns high
      if (i_clk_gate) begin
        next_s.lp = LP_RUN;
      end
    end else if (!s.cke_q) begin
      // Internal clock stopped: bursts, pipeline and outputs hold
      // The edge that sees the gate low still runs
      next_s.lp = i_clk_gate ? LP_RUN : s.lp;
    end else begin
      // Continue a running burst by one beat
      if (s.burst_on) begin
        acc_on   = 1'b1;
        acc_wr   = s.burst_wr;
        acc_col  = sci_col(s.burst_start, s.burst_cnt, s.burst_len,
                           s.mode[`SCI_MR_BT_BIT]);
        next_s.burst_cnt = `SCI_LEN_W'(s.burst_cnt + `SCI_LEN_1);
        if (`SCI_LEN_W'(s.burst_cnt + `SCI_LEN_1) == s.burst_len) begin
          next_s.burst_on = 1'b0;
        end
      end
      case (cmd)
        CMD_RD, CMD_WR: begin
          // New access overrides any burst; accepted every cycle
          if (s.mode_valid && s.bank_active[i_bank_sel_lines]) begin
            acc_on             = 1'b1;
            acc_wr             = cmd == CMD_WR;
            acc_bank           = i_bank_sel_lines;
            acc_col            = i_mux_addr_lines[`SCI_COL_W-1:0];
            next_s.burst_wr    = cmd == CMD_WR;
            next_s.burst_bank  = i_bank_sel_lines;
            next_s.burst_start = i_mux_addr_lines[`SCI_COL_W-1:0];
            next_s.burst_len   = new_len;
            next_s.burst_cnt   = `SCI_LEN_1;
            next_s.burst_on    = new_len != `SCI_LEN_1;
          end
        end
        CMD_ACT: begin
          next_s.bank_active[i_bank_sel_lines] = 1'b1;
          next_s.open_row[i_bank_sel_lines]    = i_mux_addr_lines;
        end
        CMD_PRE: begin
          if (i_mux_addr_lines[`SCI_PALL_BIT]) begin
            next_s.bank_active = '0;
          end else begin
            next_s.bank_active[i_bank_sel_lines] = 1'b0;
          end
          // Ends the burst with no beat at this edge
          if (i_mux_addr_lines[`SCI_PALL_BIT] || i_bank_sel_lines == s.burst_bank) begin
            acc_on          = 1'b0;
            next_s.burst_on = 1'b0;
          end
        end
        CMD_BST: begin
          // Drops the beat of this edge too
          acc_on          = 1'b0;
          next_s.burst_on = 1'b0;
        end
        CMD_MRS: begin
          // Taken in any bank state; idle banks are the controller's duty
          next_s.mode       = i_mux_addr_lines;
          next_s.mode_valid = 1'b1;
        end
        default: begin
          // No-operation, deselect and refresh leave the access path alone
        end
      endcase
      // Read pipeline: first stage holds the word fetched at the command edge
      // Mask comes from the registered copy to line up with output time
      next_s.rd0.valid = acc_on & ~acc_wr;
      next_s.rd0.data  = rd_data;
      next_s.rd1       = s.rd0;
      next_s.dq_out    = out_sel.data;
      next_s.dq_oe     = {`SCI_BYTES{out_sel.valid}} & ~s.dqm_q;
      // Clock gate falling selects the low power state
      // Data in flight makes it a suspend so the burst resumes later
      if (!i_clk_gate) begin
        if (cmd == CMD_SELF_REF) begin
          next_s.lp = LP_SELF_REFRESH;
        end else if (s.burst_on || s.rd0.valid || s.rd1.valid) begin
          next_s.lp = LP_SUSPEND;
        end else begin
          next_s.lp = LP_POWER_DOWN;
        end
      end else begin
        next_s.lp = LP_RUN;
      end
    end
    // One flop per status flag so the crossing sees clean levels
    next_s.lp_flags = {next_s.lp == LP_SELF_REFRESH, next_s.lp == LP_SUSPEND,
                       next_s.lp == LP_POWER_DOWN};
  end

  // Link domain registers; mode register content starts unprogrammed
  always_ff @(posedge i_link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_io_data_lines    = s.dq_out;
  assign o_io_data_lines_oe = s.dq_oe;

  // Status levels carried into the system clock domain
  // Flags are levels; a brief mix across bits is harmless
  sci_sync #(
    .W (`SCI_BANKS + 4)
  ) u_status (
    .i_clk   (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({s.mode_valid, s.bank_active, s.lp_flags}),
    .o_q     ({o_mode_valid, o_bank_active, o_self_refresh, o_suspend, o_power_down})
  );

endmodule

// *** sci_core_props.sv ***
// Port assertions for the SDRAM command interface core
`timescale 1ns/1ps
`include "sci_params.svh"
module sci_core_props (
  input wire logic                   i_mclk,
  input wire logic                   i_rst_n,
  input wire logic                   i_link_clk,
  input wire logic                   i_clk_gate,
  input wire logic                   i_chip_sel_n,
  input wire logic                   i_row_strobe_n,
  input wire logic                   i_col_strobe_n,
  input wire logic                   i_write_sel_n,
  input wire logic [`SCI_BANK_W-1:0] i_bank_sel_lines,
  input wire logic [`SCI_ROW_W-1:0]  i_mux_addr_lines,
  input wire logic                   i_upper_byte_mask,
  input wire logic                   i_lower_byte_mask,
  input wire logic [`SCI_BYTES-1:0]  o_io_data_lines_oe,
  input wire logic                   o_mode_valid,
  input wire logic [`SCI_BANKS-1:0]  o_bank_active,
  input wire logic                   o_power_down,
  input wire logic                   o_suspend,
  input wire logic                   o_self_refresh
);
  logic [1:0]            alive_q;
  logic                  cke_q;
  logic                  mrs_seen;
  logic                  cl2;
  logic [`SCI_BANKS-1:0] exp_banks;
  logic [2:0]            op;
  logic                  go;
  logic                  rd_ok;
  logic                  lp;
  // Command decode as the device sees it
  assign op = {i_row_strobe_n, i_col_strobe_n, i_write_sel_n};
  assign go = alive_q[1] && cke_q && !i_chip_sel_n;
  assign rd_ok = go && op == `SCI_OP_RD && mrs_seen && exp_banks[i_bank_sel_lines];
  assign lp = o_power_down || o_suspend || o_self_refresh;
  // Reference copy of mode and bank state
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alive_q   <= '0;
      cke_q     <= 1'b0;
      mrs_seen  <= 1'b0;
      cl2       <= 1'b0;
      exp_banks <= '0;
    end else begin
      alive_q <= {alive_q[0], 1'b1};
      cke_q   <= i_clk_gate;
      if (go && op == `SCI_OP_MRS) begin
        mrs_seen <= 1'b1;
        cl2      <= i_mux_addr_lines[`SCI_MR_CL_LSB +: `SCI_MR_CL_W] == `SCI_CL_2;
      end
      if (go && op == `SCI_OP_ACT) exp_banks[i_bank_sel_lines] <= 1'b1;
      if (go && op == `SCI_OP_PRE) begin
        if (i_mux_addr_lines[`SCI_PALL_BIT]) exp_banks <= '0;
        else exp_banks[i_bank_sel_lines] <= 1'b0;
      end
    end
  end
  AST_BANKS: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    o_bank_active == exp_banks) else $error("bank flags differ from command history");
  AST_MODE_SET: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    go && op == `SCI_OP_MRS |=> o_mode_valid) else $error("mode set not taken");
  AST_MODE_UNSET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !mrs_seen |-> !o_mode_valid) else $error("mode valid without mode set");
  AST_RD_CL2: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    (rd_ok && cl2 && !i_lower_byte_mask && i_clk_gate) ##1 i_clk_gate [*2]
    |-> o_io_data_lines_oe[0]) else $error("read data late at latency two");
  AST_RD_CL3: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    (rd_ok && !cl2 && i_clk_gate) ##1 (i_clk_gate && !i_lower_byte_mask) ##1 i_clk_gate [*2]
    |-> o_io_data_lines_oe[0]) else $error("read data late at latency three");
  AST_MASK_UP: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    (i_upper_byte_mask && i_clk_gate && cke_q) ##1 i_clk_gate
    |=> !o_io_data_lines_oe[1]) else $error("upper lane driven under mask");
  AST_MASK_LO: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    (i_lower_byte_mask && i_clk_gate && cke_q) ##1 i_clk_gate
    |=> !o_io_data_lines_oe[0]) else $error("lower lane driven under mask");
  AST_LP_ON: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    !i_clk_gate [*3] |-> lp) else $error("no low power state with clock gate low");
  AST_LP_OFF: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    i_clk_gate [*3] |-> !lp) else $error("low power state with clock gate high");
  // Main scenarios reached
  cover property (@(posedge i_link_clk) go && op == `SCI_OP_MRS);
  cover property (@(posedge i_link_clk) rd_ok && !cl2);
  cover property (@(posedge i_mclk) o_self_refresh);
  cover property (@(posedge i_mclk) o_suspend);
endmodule

bind sci_core sci_core_props u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_clk_gate(i_clk_gate),
  .i_chip_sel_n(i_chip_sel_n), .i_row_strobe_n(i_row_strobe_n),
  .i_col_strobe_n(i_col_strobe_n), .i_write_sel_n(i_write_sel_n),
  .i_bank_sel_lines(i_bank_sel_lines), .i_mux_addr_lines(i_mux_addr_lines),
  .i_upper_byte_mask(i_upper_byte_mask), .i_lower_byte_mask(i_lower_byte_mask),
  .o_io_data_lines_oe(o_io_data_lines_oe), .o_mode_valid(o_mode_valid),
  .o_bank_active(o_bank_active), .o_power_down(o_power_down), .o_suspend(o_suspend),
  .o_self_refresh(o_self_refresh));

// *** sci_ctl_model.sv ***
// Behavioural memory controller driving the device command pins
`timescale 1ns/1ps
`include "sci_params.svh"
module sci_ctl_model #(
  parameter int INIT_PAUSE_CYC   = 6667,
  parameter int ROW_TO_COL_DELAY = 2,
  parameter int ROW_CYCLE_TIME   = 4,
  parameter int MODE_SET_DELAY   = 2
) (
  input  wire logic [`SCI_DQ_W-1:0]   i_dq,
  input  wire logic [`SCI_BYTES-1:0]  i_dq_oe,
  output logic                        o_link_clk,
  output logic                        o_clk_gate,
  output logic                        o_chip_sel_n,
  output logic [2:0]                  o_op,
  output logic [`SCI_BANK_W-1:0]      o_bank,
  output logic [`SCI_ROW_W-1:0]       o_addr,
  output logic [`SCI_DQ_W-1:0]        o_dq,
  output logic [`SCI_BYTES-1:0]       o_mask
);
  logic                  cke = 1'b1;
  logic                  wr_en = 1'b0;
  logic [`SCI_DQ_W-1:0]  wdata = '0;
  logic [`SCI_BYTES-1:0] mask = 2'b11;
  logic [`SCI_DQ_W-1:0]  cap_d;
  logic [`SCI_BYTES-1:0] cap_oe;
  // Idle pins at power on: no-operation, masks and clock gate high
  initial begin
    o_link_clk = 1'b0;
    o_dq       = '0;
    pins(1'b0, `SCI_OP_NOP, '0, '0);
    #7.3;
    forever #15 o_link_clk = ~o_link_clk;
  end
  // One link cycle: capture what the device shows, then drive the next command
  task automatic step(input logic cs_n, input logic [2:0] op,
                      input logic [1:0] bank, input logic [11:0] addr);
    #1;
    cap_d        = i_dq;
    cap_oe       = i_dq_oe;
    pins(cs_n, op, bank, addr);
    @(posedge o_link_clk);
  endtask
  // Put one command, its data and the masks on the pins
  task automatic pins(input logic cs_n, input logic [2:0] op,
                      input logic [1:0] bank, input logic [11:0] addr);
    o_clk_gate   = cke;
    o_chip_sel_n = cs_n;
    o_op         = op;
    o_bank       = bank;
    o_addr       = addr;
    o_dq         = wr_en ? wdata : ~o_dq;   // Released bus never holds its last value
    o_mask       = mask;
  endtask
  task automatic no_operation(input int n);
    repeat (n) step(1'b0, `SCI_OP_NOP, '0, '0);
  endtask
  // Power-up pause, precharge all, eight refreshes, mode set
  task automatic init(input logic [11:0] mode);
    @(posedge o_link_clk);
    no_operation(INIT_PAUSE_CYC);
    mask = 2'b00;
    step(1'b0, `SCI_OP_PRE, '0, 12'h400);
    repeat (8) begin
      step(1'b0, `SCI_OP_REF, '0, '0);
      no_operation(ROW_CYCLE_TIME);
    end
    step(1'b0, `SCI_OP_MRS, '0, mode);
    no_operation(MODE_SET_DELAY);
  endtask
  task automatic act(input logic [1:0] bank, input logic [11:0] row);
    step(1'b0, `SCI_OP_ACT, bank, row);
    no_operation(ROW_CYCLE_TIME > ROW_TO_COL_DELAY ? ROW_CYCLE_TIME : ROW_TO_COL_DELAY);
  endtask
  task automatic pre(input logic [1:0] bank, input logic [11:0] addr);
    step(1'b0, `SCI_OP_PRE, bank, addr);
    no_operation(2);
  endtask
endmodule

// *** sci_core_tb_top.sv ***
// Self-checking bench for the SDRAM command interface core
`timescale 1ns/1ps
`include "sci_params.svh"
module sci_core_tb_top;
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   lclk;
  logic                   cke;
  logic                   cs_n;
  logic [2:0]             op;
  logic [`SCI_BANK_W-1:0] bank;
  logic [`SCI_ROW_W-1:0]  addr;
  logic [`SCI_DQ_W-1:0]   wdq;
  logic [`SCI_DQ_W-1:0]   rdq;
  logic [`SCI_BYTES-1:0]  mask;
  logic [`SCI_BYTES-1:0]  oe;
  logic                   mode_v;
  logic [`SCI_BANKS-1:0]  bact;
  logic                   pdn;
  logic                   susp;
  logic                   sref;
  int                     n_mismatch = 0;
  int                     total_checks = 0;
  int                     cyc = 0;
  logic [15:0]            bd [7];
  logic [1:0]             bo [7];
  // System clock, 250 MHz
  always #2 mclk = ~mclk;
  sci_core dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_clk_gate(cke),
    .i_chip_sel_n(cs_n), .i_row_strobe_n(op[2]), .i_col_strobe_n(op[1]),
    .i_write_sel_n(op[0]), .i_bank_sel_lines(bank), .i_mux_addr_lines(addr),
    .i_io_data_lines(wdq), .o_io_data_lines(rdq), .o_io_data_lines_oe(oe),
    .i_upper_byte_mask(mask[1]), .i_lower_byte_mask(mask[0]), .o_mode_valid(mode_v),
    .o_bank_active(bact), .o_power_down(pdn), .o_suspend(susp), .o_self_refresh(sref));
  sci_ctl_model #(.INIT_PAUSE_CYC(8)) m (.i_dq(rdq), .i_dq_oe(oe), .o_link_clk(lclk),
    .o_clk_gate(cke), .o_chip_sel_n(cs_n), .o_op(op), .o_bank(bank), .o_addr(addr),
    .o_dq(wdq), .o_mask(mask));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Four-beat write; lower lane masked on beat mb; later beats under chip deselect
  task automatic wr4(input logic [1:0] b, input logic [11:0] col, input logic [15:0] base,
                     input int mb);
    m.wr_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      m.wdata = base + 16'(k);
      m.mask = (k == mb) ? 2'b01 : 2'b00;
      if (k == 0) m.step(1'b0, `SCI_OP_WR, b, col);
      else m.step(1'b1, 3'h0, b, col);
    end
    m.wr_en = 1'b0;
    m.mask = 2'b00;
  endtask
  // Read, optional second read to bank b2 next cycle, deselects with all strobes low
  task automatic rd(input logic [1:0] b, input logic [11:0] col, input int um, input int b2);
    for (int k = 0; k < 7; k++) begin
      m.mask = (k == um) ? 2'b10 : 2'b00;
      if (k == 0) m.step(1'b0, `SCI_OP_RD, b, col);
      else if (k == 1 && b2 >= 0) m.step(1'b0, `SCI_OP_RD, 2'(b2), col);
      else m.step(1'b1, 3'h0, b, col);
      bd[k] = m.cap_d;
      bo[k] = m.cap_oe;
    end
    m.mask = 2'b00;
  endtask
  task automatic t_banks();
    m.act(2'd1, 12'h5A3);
    m.act(2'd2, 12'h0F0);
    chk("banks open", 16'h0006, {12'h0, bact});
  endtask
  task automatic t_rw();
    wr4(2'd1, 12'h810, 16'h1111, 4);
    wr4(2'd2, 12'h010, 16'h2200, 4);
    wr4(2'd1, 12'h010, 16'hA0C0, 1);
    rd(2'd1, 12'h010, 2, -1);
    chk("beat0", 16'hA0C0, bd[2]);
    chk("beat1", 16'hA012, bd[3]);
    chk("beat2 lower", 16'h00C2, {8'h00, bd[4][7:0]});
    chk("beat2 enables", 16'h0001, {14'h0, bo[4]});
    chk("beat3", 16'hA0C3, bd[5]);
    chk("after burst enables", 16'h0000, {14'h0, bo[6]});
  endtask
  task automatic t_inter();
    rd(2'd1, 12'h010, -1, 2);
    chk("first bank beat", 16'hA0C0, bd[2]);
    chk("second bank beat0", 16'h2200, bd[3]);
    chk("second bank beat1", 16'h2201, bd[4]);
  endtask
  task automatic t_pre();
    m.pre(2'd2, 12'h000);
    chk("one bank closed", 16'h0002, {12'h0, bact});
    m.act(2'd3, 12'h001);
    m.pre(2'd0, 12'h400);
    chk("all banks closed", 16'h0000, {12'h0, bact});
  endtask
  task automatic t_power();
    m.cke = 1'b0;
    m.no_operation(3);
    chk("power down", 16'h0001, {15'h0, pdn});
    m.cke = 1'b1;
    m.no_operation(3);
    chk("awake", 16'h0000, {13'h0, pdn, susp, sref});
    m.cke = 1'b0;
    m.step(1'b0, `SCI_OP_REF, '0, '0);
    m.no_operation(3);
    chk("self refresh", 16'h0001, {13'h0, pdn, susp, sref});
    m.cke = 1'b1;
    m.no_operation(3);
    chk("awake again", 16'h0000, {13'h0, pdn, susp, sref});
    m.act(2'd1, 12'h5A3);
    m.step(1'b0, `SCI_OP_RD, 2'd1, 12'h010);
    m.cke = 1'b0;
    m.no_operation(3);
    chk("suspend", 16'h0002, {13'h0, pdn, susp, sref});
    m.cke = 1'b1;
    m.no_operation(1);
    m.pre(2'd0, 12'h400);
  endtask
  task automatic t_cl3();
    m.step(1'b0, `SCI_OP_MRS, '0, 12'h031);
    m.no_operation(2);
    m.act(2'd1, 12'h5A3);
    rd(2'd1, 12'h010, -1, -1);
    chk("late beat0", 16'hA0C0, bd[3]);
    chk("late beat1", 16'hA012, bd[4]);
    chk("burst of two ends", 16'h0000, {14'h0, bo[5]});
    m.step(1'b0, `SCI_OP_RD, 2'd1, 12'h010);
    m.step(1'b0, `SCI_OP_BST, '0, '0);
    m.no_operation(3);
    chk("burst stop", 16'h0000, {14'h0, m.cap_oe});
  endtask
  // Cuts a hung run short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("mode before set", 16'h0000, {15'h0, mode_v});
    m.init(12'h022);
    chk("mode after set", 16'h0001, {15'h0, mode_v});
    t_banks();
    t_rw();
    t_inter();
    t_pre();
    t_power();
    t_cl3();
    close_out();
  end
endmodule
